// ===== hdl/serial_port_pkg.sv
package serial_port_pkg;

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_BITRATE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_TXDATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RXDATA = 8'h14;
	localparam logic [7:0] OFS_FIFOCTL = 8'h18;
	localparam logic [7:0] OFS_FIFOCNT = 8'h1C;

	// ----------------------------------------
	// reset values and write masks
	// ----------------------------------------
	localparam logic [15:0] STATUS_RESET = 16'h0060;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BITRATE_RESET = 8'h00;
	localparam logic [7:0] FIFOCTL_RESET = 8'h00;
	localparam logic [7:0] MODE_RSV_MASK = 8'h84;
	localparam logic [7:0] CONTROL_RSV_MASK = 8'h0C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MODE_CHR = 6;
	localparam int MODE_PE = 5;
	localparam int MODE_ODD = 4;
	localparam int MODE_STOP = 3;
	localparam int MODE_CKS = 0;
	localparam int CTL_TX_EN = 5;
	localparam int CTL_RX_EN = 4;
	localparam int CTL_CLK_SRC = 1;
	localparam int CTL_CLK_OUT = 0;
	localparam int ST_RX_ERR = 7;
	localparam int ST_TX_END = 6;
	localparam int ST_TX_EMPTY = 5;
	localparam int FCR_TTRG = 4;

	// ----------------------------------------
	// fifo and line timing
	// ----------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] START_MID = 4'h7;
	localparam logic [4:0] TX_TRIG_SEL0 = 5'h08;
	localparam logic [4:0] TX_TRIG_SEL1 = 5'h04;
	localparam logic [4:0] TX_TRIG_SEL2 = 5'h02;
	localparam logic [4:0] TX_TRIG_SEL3 = 5'h01;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

endpackage

// ===== hdl/serial_port.sv
`timescale 1ns/1ps
// Function
// - receiver runs only while receive_enable set
// - disabling receiver keeps all receive flags
// - reception starts only on detected start bit
// - control bits 3,2 read zero, written zero
// - clock pair picks internal, output or external
// - clock_output_select ignored under external clock
// - serial clock runs at sixteen times bitrate
// - status: error count high, flags low
// - software clears flags only by zero after read
// - framing and parity bits are read-only
// - reset and standby load status 0x0060
// - zero first stop bit sets receive error
// - parity mismatch sets receive error
// - receive error cleared by reset or software
// - bad characters still stored, marked per entry
// - only first stop bit is checked
// - transmit end set at idle or disable
// - transmit fifo write clears transmit end
// - empty flag set when drained below trigger
// - empty flag cleared by refill or software
// - sixteen byte fifo, excess writes dropped
module serial_port #(
	parameter int FIFO_DEPTH = serial_port_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic standby,
	input wire logic [serial_port_pkg::ADDR_W-1:0] addr,
	input wire logic [serial_port_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [serial_port_pkg::DATA_W-1:0] rdata,
	input wire logic rxd,
	output logic txd,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe
);
	import serial_port_pkg::*;

	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(FIFO_DEPTH);
	localparam logic [2:0] FLAG_RESET = {STATUS_RESET[ST_RX_ERR], STATUS_RESET[ST_TX_END],
		STATUS_RESET[ST_TX_EMPTY]};

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic [7:0] mode_reg, bitrate_reg, control_reg, fifoctl_reg;
	logic [15:0] rdata_reg;
	wire wr_mode = wr && addr == OFS_MODE;
	wire wr_bitrate = wr && addr == OFS_BITRATE;
	wire wr_control = wr && addr == OFS_CONTROL;
	wire wr_txdata = wr && addr == OFS_TXDATA;
	wire wr_status = wr && addr == OFS_STATUS;
	wire wr_fifoctl = wr && addr == OFS_FIFOCTL;
	wire rd_status = rd && addr == OFS_STATUS;
	wire rd_rxdata = rd && addr == OFS_RXDATA;

	wire chr = mode_reg[MODE_CHR];
	wire pe = mode_reg[MODE_PE];
	wire odd = mode_reg[MODE_ODD];
	wire two_stop = mode_reg[MODE_STOP];
	wire [1:0] cks = mode_reg[MODE_CKS+1:MODE_CKS];
	wire tx_en = control_reg[CTL_TX_EN];
	wire rx_en = control_reg[CTL_RX_EN];
	wire clk_src = control_reg[CTL_CLK_SRC];
	wire clk_out = control_reg[CTL_CLK_OUT];
	wire tx_en_fall = wr_control && tx_en && !wdata[CTL_TX_EN];

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_reg <= MODE_RESET;
			bitrate_reg <= BITRATE_RESET;
			control_reg <= CONTROL_RESET;
			fifoctl_reg <= FIFOCTL_RESET;
		end
		else if (standby)
		begin
			mode_reg <= MODE_RESET;
			bitrate_reg <= BITRATE_RESET;
			control_reg <= CONTROL_RESET;
			fifoctl_reg <= FIFOCTL_RESET;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= wdata[7:0] & ~MODE_RSV_MASK;
			if (wr_bitrate)
				bitrate_reg <= wdata[7:0];
			if (wr_control)
				control_reg <= wdata[7:0] & ~CONTROL_RSV_MASK;
			if (wr_fifoctl)
				fifoctl_reg <= wdata[7:0];
		end
	end

	// ----------------------------------------
	// 16x bit clock: internal divider or sck pin
	// ----------------------------------------
	logic [15:0] div_cnt_reg;
	logic clk_int_reg, sck_meta_reg, sck_sync_reg, sck_prev_reg, sck_oe_reg;
	wire [15:0] div_limit = (({8'h00, bitrate_reg} + 16'h0001) << {cks, 1'b0}) - 16'h0001;
	wire div_wrap = div_cnt_reg >= div_limit;
	wire int_rise = !clk_src && div_wrap && !clk_int_reg;
	wire ext_rise = clk_src && sck_sync_reg && !sck_prev_reg;
	// one tick per sck period, so a full bit is sixteen ticks
	wire tick16 = int_rise || ext_rise;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt_reg <= 16'h0000;
			clk_int_reg <= 1'b0;
		end
		else if (standby || clk_src)
		begin
			div_cnt_reg <= 16'h0000;
			clk_int_reg <= 1'b0;
		end
		else if (div_wrap)
		begin
			div_cnt_reg <= 16'h0000;
			clk_int_reg <= !clk_int_reg;
		end
		else
			div_cnt_reg <= div_cnt_reg + 16'h0001;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sck_meta_reg <= 1'b0;
			sck_sync_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			sck_oe_reg <= 1'b0;
		end
		else
		begin
			sck_meta_reg <= sck_i;
			sck_sync_reg <= sck_meta_reg;
			sck_prev_reg <= sck_sync_reg;
			sck_oe_reg <= !standby && !clk_src && clk_out;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	rx_state_t rx_state;
	logic [3:0] rx_cnt_reg, rx_bits_reg;
	logic [7:0] rx_shift_reg;
	logic rx_par_reg, rxd_meta_reg, rxd_sync_reg;
	wire [3:0] nbits = chr ? 4'h7 : 4'h8;
	wire [3:0] rx_bits_inc = rx_bits_reg + 4'h1;
	wire rx_sample = tick16 && rx_cnt_reg == OVERSAMPLE_LAST;
	wire [7:0] rx_data = chr ? {1'b0, rx_shift_reg[7:1]} : rx_shift_reg;
	wire rx_frame_err = !rxd_sync_reg;
	wire rx_par_err = pe && (^{rx_data, rx_par_reg, odd});
	wire rx_new_err = rx_frame_err || rx_par_err;
	wire rx_done = rx_state == RX_STOP && rx_sample;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end
		else
		begin
			rxd_meta_reg <= rxd;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_state <= RX_IDLE;
			rx_cnt_reg <= 4'h0;
			rx_bits_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			rx_par_reg <= 1'b0;
		end
		else if (standby || !rx_en)
		begin
			rx_state <= RX_IDLE;
			rx_cnt_reg <= 4'h0;
		end
		else
		begin
			unique case (rx_state)
				RX_IDLE:
					if (!rxd_sync_reg)
					begin
						rx_state <= RX_START;
						rx_cnt_reg <= 4'h0;
					end
				RX_START:
					if (tick16 && rx_cnt_reg == START_MID)
					begin
						// a glitch shorter than half a bit is not a start
						rx_state <= rxd_sync_reg ? RX_IDLE : RX_DATA;
						rx_cnt_reg <= 4'h0;
						rx_bits_reg <= 4'h0;
					end
					else if (tick16)
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
				RX_DATA:
				begin
					if (tick16)
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
					if (rx_sample)
					begin
						rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
						rx_bits_reg <= rx_bits_inc;
						if (rx_bits_inc == nbits)
							rx_state <= pe ? RX_PARITY : RX_STOP;
					end
				end
				RX_PARITY:
				begin
					if (tick16)
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
					if (rx_sample)
					begin
						rx_par_reg <= rxd_sync_reg;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (tick16)
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
					// back to idle after the first stop: a low second stop is a new start
					if (rx_sample)
						rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// receive fifo with per-entry error bits
	// ----------------------------------------
	logic [9:0] rx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] rx_wptr_reg, rx_rptr_reg;
	logic [CNT_W-1:0] rx_count_reg;
	logic [7:0] err_cnt_reg;
	logic frame_err_reg, par_err_reg;
	// a full fifo drops the character; no overrun flag is kept
	wire rx_push = rx_done && rx_count_reg != FIFO_FULL;
	wire rx_pop = rd_rxdata && rx_count_reg != '0;
	wire [9:0] rx_head = rx_mem[rx_rptr_reg];
	wire rx_head_err = rx_head[9] || rx_head[8];

	always_ff @(posedge mclk)
	begin
		if (rx_push)
			rx_mem[rx_wptr_reg] <= {rx_par_err, rx_frame_err, rx_data};
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_wptr_reg <= '0;
			rx_rptr_reg <= '0;
			rx_count_reg <= '0;
			err_cnt_reg <= 8'h00;
			frame_err_reg <= 1'b0;
			par_err_reg <= 1'b0;
		end
		else if (standby)
		begin
			rx_wptr_reg <= '0;
			rx_rptr_reg <= '0;
			rx_count_reg <= '0;
			err_cnt_reg <= 8'h00;
			frame_err_reg <= 1'b0;
			par_err_reg <= 1'b0;
		end
		else
		begin
			rx_wptr_reg <= rx_wptr_reg + PTR_W'(rx_push);
			rx_rptr_reg <= rx_rptr_reg + PTR_W'(rx_pop);
			rx_count_reg <= rx_count_reg + CNT_W'(rx_push) - CNT_W'(rx_pop);
			err_cnt_reg <= err_cnt_reg + 8'(rx_push && rx_new_err)
				- 8'(rx_pop && rx_head_err);
			if (rx_pop)
			begin
				frame_err_reg <= rx_head[8];
				par_err_reg <= rx_head[9];
			end
		end
	end

	// ----------------------------------------
	// transmit fifo and transmitter
	// ----------------------------------------
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] tx_wptr_reg, tx_rptr_reg;
	logic [CNT_W-1:0] tx_count_reg;
	tx_state_t tx_state;
	logic [3:0] tx_cnt_reg, tx_bits_reg;
	logic [7:0] tx_shift_reg;
	logic tx_par_reg, tx_stop2_reg, txd_reg;
	wire [1:0] ttrg = fifoctl_reg[FCR_TTRG+1:FCR_TTRG];
	wire [4:0] trig_sel = ttrg == 2'b00 ? TX_TRIG_SEL0 : ttrg == 2'b01 ? TX_TRIG_SEL1 :
		ttrg == 2'b10 ? TX_TRIG_SEL2 : TX_TRIG_SEL3;
	wire [CNT_W-1:0] tx_trig = CNT_W'(trig_sel);
	wire tx_push = wr_txdata && tx_count_reg != FIFO_FULL;
	wire tx_pop = tx_state == TX_IDLE && tx_en && tx_count_reg != '0;
	wire [CNT_W-1:0] tx_count_next = tx_count_reg + CNT_W'(tx_push) - CNT_W'(tx_pop);
	wire [7:0] tx_head = tx_mem[tx_rptr_reg];
	wire [7:0] tx_head_m = chr ? {1'b0, tx_head[6:0]} : tx_head;
	wire [3:0] tx_bits_inc = tx_bits_reg + 4'h1;
	wire tx_bit_end = tick16 && tx_cnt_reg == OVERSAMPLE_LAST;
	wire tx_last_stop = tx_state == TX_STOP && tx_bit_end && (!two_stop || tx_stop2_reg);

	always_ff @(posedge mclk)
	begin
		if (tx_push)
			tx_mem[tx_wptr_reg] <= wdata[7:0];
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_wptr_reg <= '0;
			tx_rptr_reg <= '0;
			tx_count_reg <= '0;
		end
		else if (standby)
		begin
			tx_wptr_reg <= '0;
			tx_rptr_reg <= '0;
			tx_count_reg <= '0;
		end
		else
		begin
			tx_wptr_reg <= tx_wptr_reg + PTR_W'(tx_push);
			tx_rptr_reg <= tx_rptr_reg + PTR_W'(tx_pop);
			tx_count_reg <= tx_count_next;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_state <= TX_IDLE;
			tx_cnt_reg <= 4'h0;
			tx_bits_reg <= 4'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
			tx_stop2_reg <= 1'b0;
			txd_reg <= 1'b1;
		end
		else if (standby || !tx_en)
		begin
			tx_state <= TX_IDLE;
			tx_cnt_reg <= 4'h0;
			txd_reg <= 1'b1;
		end
		else
		begin
			if (tick16 && tx_state != TX_IDLE)
				tx_cnt_reg <= tx_cnt_reg + 4'h1;
			unique case (tx_state)
				TX_IDLE:
					if (tx_pop)
					begin
						tx_shift_reg <= tx_head_m;
						tx_par_reg <= ^{tx_head_m, odd};
						tx_state <= TX_START;
						tx_cnt_reg <= 4'h0;
						tx_bits_reg <= 4'h0;
						tx_stop2_reg <= 1'b0;
						txd_reg <= 1'b0;
					end
				TX_START:
					if (tx_bit_end)
					begin
						txd_reg <= tx_shift_reg[0];
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_state <= TX_DATA;
					end
				TX_DATA:
					if (tx_bit_end)
					begin
						tx_bits_reg <= tx_bits_inc;
						if (tx_bits_inc == nbits)
						begin
							txd_reg <= pe ? tx_par_reg : 1'b1;
							tx_state <= pe ? TX_PARITY : TX_STOP;
						end
						else
						begin
							txd_reg <= tx_shift_reg[0];
							tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						end
					end
				TX_PARITY:
					if (tx_bit_end)
					begin
						txd_reg <= 1'b1;
						tx_state <= TX_STOP;
					end
				TX_STOP:
					if (tx_bit_end && two_stop && !tx_stop2_reg)
						tx_stop2_reg <= 1'b1;
					else if (tx_bit_end)
						tx_state <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// status flags: {rx error, tx end, tx empty}
	// ----------------------------------------
	wire empty_set = tx_pop && !tx_push && tx_count_reg >= tx_trig
		&& tx_count_next < tx_trig;
	wire empty_hwclr = tx_push && tx_count_next > tx_trig;
	wire end_set = (tx_last_stop && tx_count_reg == '0) || tx_en_fall;
	wire [2:0] flag_set = {rx_done && rx_new_err, end_set, empty_set};
	wire [2:0] flag_hwclr = {1'b0, tx_push, empty_hwclr};
	wire [2:0] flag_wbit = {wdata[ST_RX_ERR], wdata[ST_TX_END], wdata[ST_TX_EMPTY]};
	wire [2:0] flag_vec;
	wire [2:0] armed_vec;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : flag_g
			logic flag_q, armed_q;
			// a written one is no clear; a zero only clears after a read saw it set
			wire sw_clr = wr_status && !flag_wbit[g] && armed_q;
			// hardware set beats any clear in the same cycle
			wire nxt = flag_set[g] || (flag_q && !sw_clr && !flag_hwclr[g]);
			assign flag_vec[g] = flag_q;
			assign armed_vec[g] = armed_q;
			always_ff @(posedge mclk or negedge rstn)
			begin
				if (!rstn)
				begin
					flag_q <= FLAG_RESET[g];
					armed_q <= 1'b0;
				end
				else if (standby)
				begin
					flag_q <= FLAG_RESET[g];
					armed_q <= 1'b0;
				end
				else
				begin
					flag_q <= nxt;
					armed_q <= nxt && (armed_q || (rd_status && flag_q));
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire [15:0] status_w = {err_cnt_reg, flag_vec, 1'b0, frame_err_reg, par_err_reg,
		2'b00};
	wire [7:0] rx_rd_byte = rx_count_reg != '0 ? rx_head[7:0] : 8'h00;
	wire [15:0] rd_mux = addr == OFS_MODE ? {8'h00, mode_reg} :
		addr == OFS_BITRATE ? {8'h00, bitrate_reg} :
		addr == OFS_CONTROL ? {8'h00, control_reg} :
		addr == OFS_STATUS ? status_w :
		addr == OFS_RXDATA ? {8'h00, rx_rd_byte} :
		addr == OFS_FIFOCTL ? {8'h00, fifoctl_reg} :
		addr == OFS_FIFOCNT ? {8'(tx_count_reg), 8'(rx_count_reg)} : 16'h0000;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= 16'h0000;
		else
			rdata_reg <= rd ? rd_mux : 16'h0000;
	end

	assign rdata = rdata_reg;
	assign txd = txd_reg;
	assign sck_o = clk_int_reg;
	assign sck_oe = sck_oe_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence rxerr_seen_s;
		rd_status && flag_vec[2];
	endsequence
	sequence rxerr_zero_write_s;
		wr_status && !wdata[ST_RX_ERR] && !flag_set[2] && !standby;
	endsequence

	rx_off_idle_a: assert property (!rx_en |=> rx_state == RX_IDLE)
		else $error("receiver active while disabled");
	rx_start_only_a: assert property (rx_state == RX_IDLE && rxd_sync_reg
		|=> rx_state == RX_IDLE)
		else $error("reception began without start bit");
	ctl_rsv_zero_a: assert property (control_reg[3:2] == 2'b00)
		else $error("control reserved bits not zero");
	sck_dir_a: assert property (!standby
		|=> sck_oe == (!$past(clk_src) && $past(clk_out)))
		else $error("sck direction does not follow clock select");
	ext_no_out_a: assert property (clk_src ##1 clk_src |-> !sck_oe)
		else $error("sck driven under external clock");
	status_init_a: assert property (standby |=> status_w == STATUS_RESET)
		else $error("status not 0x0060 after standby");
	rxerr_set_a: assert property (rx_done && rx_new_err && !standby |=> flag_vec[2])
		else $error("receive error not flagged");
	// one idle cycle between read and write, as a plain master issues them
	rxerr_clear_a: assert property (rxerr_seen_s ##1 !wr_status ##1 rxerr_zero_write_s
		|=> !flag_vec[2])
		else $error("read then zero write did not clear");
	rxerr_fall_a: assert property ($fell(flag_vec[2]) && !$past(standby)
		|-> $past(armed_vec[2]))
		else $error("receive error cleared without prior read");
	one_write_a: assert property (wr_status && wdata[ST_RX_ERR] && !standby
		|=> !$fell(flag_vec[2]))
		else $error("writing one changed the flag");
	ro_bits_a: assert property (wr_status && !rx_pop
		|=> $stable(frame_err_reg) && $stable(par_err_reg))
		else $error("read-only error bits changed by write");
	txend_clear_a: assert property (tx_push && !end_set && !standby |=> !flag_vec[1])
		else $error("transmit end not cleared by fifo write");
	// a pop in the same cycle may still lower the level by one
	fifo_drop_a: assert property (wr_txdata && tx_count_reg == FIFO_FULL && !standby
		|=> tx_count_reg + CNT_W'($past(tx_pop)) == FIFO_FULL)
		else $error("write accepted into full transmit fifo");
	err_bound_a: assert property (8'(rx_count_reg) >= err_cnt_reg)
		else $error("error count exceeds receive fifo level");

endmodule

// ===== bench/serial_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote serial peer
// ----------------------------------------
module serial_peer (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd,
	output logic sck_i
);
	logic ext_on;
	logic ph;
	initial
	begin
		rxd = 1'b1;
		sck_i = 1'b0;
		ext_on = 1'b0;
		ph = 1'b0;
	end
	// external clock: four mclk a period, sixteen a 64-cycle bit
	always @(posedge mclk)
		if (ext_on)
		begin
			ph <= ~ph;
			if (ph)
				sck_i <= ~sck_i;
		end
	// par[1] adds a parity bit of value par[0]; a low stop is cut short
	// so the receiver cannot see it as a fresh start bit
	task automatic send(input logic [7:0] v, input int bc, input logic [1:0] par,
		input logic stp);
		logic [10:0] f;
		f = {stp, par[0], v, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			if (i == 9 && !par[1])
				continue;
			rxd <= f[i];
			repeat ((i == 10 && !stp) ? bc * 3 / 4 : bc) @(posedge mclk);
		end
		rxd <= 1'b1;
	endtask
	task automatic recv(output logic [7:0] v, input int bc);
		@(negedge txd);
		repeat (bc + bc / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			v[i] = txd;
			repeat (bc) @(posedge mclk);
		end
	endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import serial_port_pkg::*;
	`define CHK(g, e, m) check(16'(g), 16'(e), m)
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic standby = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] d;
	logic txd, rxd, sck_i, sck_o, sck_oe;
	logic [7:0] b;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 mclk = ~mclk;
	serial_port #(.FIFO_DEPTH(FIFO_DEPTH)) u_dut (.mclk(mclk), .rstn(rstn),
		.standby(standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rxd(rxd), .txd(txd), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe));
	serial_peer u_peer (.mclk(mclk), .txd(txd), .rxd(rxd), .sck_i(sck_i));
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// ----------------------------------------
	// register access, entered just after an edge
	// ----------------------------------------
	task automatic wreg(input logic [7:0] a, input logic [15:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [15:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge mclk);
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [15:0] e, input string m);
		rreg(a, d);
		`CHK(d, e, m);
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_errors++;
			complete_run();
		end
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		expect_reg(OFS_STATUS, STATUS_RESET, "status reset");
		expect_reg(OFS_CONTROL, 16'h0000, "control reset");
		expect_reg(8'h20, 16'h0000, "unmapped read");
		wreg(OFS_CONTROL, 16'h000C);
		expect_reg(OFS_CONTROL, 16'h0000, "reserved control");
		wreg(OFS_CONTROL, 16'h0001);
		@(negedge mclk);
		`CHK(sck_oe, 1'b1, "clock pin drives");
		b[0] = sck_o;
		@(negedge mclk);
		`CHK(sck_o, !b[0], "clock out toggles");
		@(posedge mclk);
		$display("test registers done");
		// ----------------------------------------
		// receive with stop error
		// ----------------------------------------
		wreg(OFS_CONTROL, 16'h0000);
		wreg(OFS_MODE, 16'h0000);
		u_peer.send(8'hC3, 32, 2'b00, 1'b1);
		expect_reg(OFS_FIFOCNT, 16'h0000, "receiver off");
		wreg(OFS_CONTROL, 16'h0010);
		repeat (100) @(posedge mclk);
		expect_reg(OFS_FIFOCNT, 16'h0000, "idle line");
		u_peer.send(8'hA5, 32, 2'b00, 1'b1);
		u_peer.send(8'h3C, 32, 2'b00, 1'b0);
		expect_reg(OFS_FIFOCNT, 16'h0002, "bad char kept");
		expect_reg(OFS_STATUS, 16'h01E0, "stop error");
		expect_reg(OFS_RXDATA, 16'h00A5, "first char");
		expect_reg(OFS_RXDATA, 16'h003C, "bad char");
		expect_reg(OFS_STATUS, 16'h00E8, "framing bit");
		wreg(OFS_STATUS, 16'h00FF);
		expect_reg(OFS_STATUS, 16'h00E8, "write ones");
		wreg(OFS_STATUS, 16'h0060);
		expect_reg(OFS_STATUS, 16'h0068, "error cleared");
		$display("test stop error done");
		// ----------------------------------------
		// parity error, clear without read
		// ----------------------------------------
		wreg(OFS_CONTROL, 16'h0000);
		wreg(OFS_MODE, 16'h0020);
		wreg(OFS_CONTROL, 16'h0010);
		u_peer.send(8'h81, 32, 2'b11, 1'b1);
		wreg(OFS_STATUS, 16'h0060);
		expect_reg(OFS_STATUS, 16'h01E8, "clear unread");
		wreg(OFS_CONTROL, 16'h0000);
		expect_reg(OFS_STATUS, 16'h01E8, "disable keeps flags");
		expect_reg(OFS_RXDATA, 16'h0081, "parity char");
		expect_reg(OFS_STATUS, 16'h00E4, "parity bit");
		wreg(OFS_STATUS, 16'h0060);
		$display("test parity done");
		// ----------------------------------------
		// two stop bits selected, peer sends one high stop
		// ----------------------------------------
		wreg(OFS_MODE, 16'h0008);
		wreg(OFS_CONTROL, 16'h0010);
		u_peer.send(8'h11, 32, 2'b00, 1'b1);
		u_peer.send(8'h22, 32, 2'b00, 1'b1);
		expect_reg(OFS_RXDATA, 16'h0011, "first of pair");
		expect_reg(OFS_RXDATA, 16'h0022, "second of pair");
		expect_reg(OFS_STATUS, 16'h0060, "no error");
		$display("test stop length done");
		// seven data bits, bit 7 of the byte goes out as the odd parity bit
		wreg(OFS_CONTROL, 16'h0000);
		wreg(OFS_MODE, 16'h0070);
		wreg(OFS_CONTROL, 16'h0010);
		u_peer.send(8'hB5, 32, 2'b00, 1'b1);
		expect_reg(OFS_RXDATA, 16'h0035, "seven bit char");
		expect_reg(OFS_STATUS, 16'h0060, "odd parity ok");
		$display("test seven bit done");
		// ----------------------------------------
		// external clock, lower bit ignored
		// ----------------------------------------
		wreg(OFS_CONTROL, 16'h0002);
		wreg(OFS_MODE, 16'h0000);
		wreg(OFS_CONTROL, 16'h0013);
		@(negedge mclk);
		`CHK(sck_oe, 1'b0, "external clock pin");
		@(posedge mclk);
		u_peer.ext_on <= 1'b1;
		u_peer.send(8'h5A, 64, 2'b00, 1'b1);
		u_peer.ext_on <= 1'b0;
		expect_reg(OFS_RXDATA, 16'h005A, "external clock char");
		$display("test external clock done");
		// ----------------------------------------
		// transmit: fill, overflow, drain
		// ----------------------------------------
		wreg(OFS_CONTROL, 16'h0000);
		wreg(OFS_FIFOCTL, 16'h0030);
		for (int i = 0; i < 17; i++)
			wreg(OFS_TXDATA, 16'(i) + 16'h00A0);
		expect_reg(OFS_FIFOCNT, 16'h1000, "overflow dropped");
		expect_reg(OFS_STATUS, 16'h0000, "fifo written");
		fork
			u_peer.recv(b, 32);
			wreg(OFS_CONTROL, 16'h0020);
		join
		`CHK(b, 8'hA0, "first sent byte");
		d = '0;
		for (int i = 0; i < 4000 && d[ST_TX_END] !== 1'b1; i++)
			rreg(OFS_STATUS, d);
		`CHK(d, 16'h0060, "drained");
		wreg(OFS_STATUS, 16'h0000);
		expect_reg(OFS_STATUS, 16'h0000, "software clear");
		wreg(OFS_CONTROL, 16'h0000);
		expect_reg(OFS_STATUS, 16'h0040, "transmit disabled");
		wreg(OFS_CONTROL, 16'h0011);
		standby <= 1'b1;
		@(posedge mclk);
		standby <= 1'b0;
		@(posedge mclk);
		expect_reg(OFS_STATUS, STATUS_RESET, "standby status");
		expect_reg(OFS_CONTROL, 16'h0000, "standby control");
		$display("test transmit done");
		complete_run();
	end
endmodule
